// File: rtl/wdt_params.svh
// Offsets, field positions, reset values and timing counts of the watchdog.
// Assumes inclusion by bare name from the watchdog design file.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_OFF_CTRL       8'h00
`define WDT_OFF_RELOAD     8'h04
`define WDT_OFF_FEED1      8'h08
`define WDT_OFF_FEED2      8'h0C
`define WDT_OFF_STATUS     8'h10

`define WDT_KEY_FIRST      8'hA5
`define WDT_KEY_SECOND     8'h5A

`define WDT_BIT_TAP_HI     7
`define WDT_BIT_TAP_LO     5
`define WDT_BIT_RUN        2
`define WDT_BIT_TOF        1

`define WDT_RST_TAP        3'h7
`define WDT_RST_RUN        1'b1
`define WDT_RST_RELOAD     8'h00

// Smallest divisor is two to this power
`define WDT_TAP_BASE       4'h5
`define WDT_RST_PULSE_CYC  16

`endif

// File: rtl/wdt_pkg.sv
// Types shared by the watchdog design.
// Assumes nothing of its surroundings.
package wdt_pkg;

    typedef enum logic {
        WDT_FEED_IDLE,
        WDT_FEED_ARMED
    } wdt_feed_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } wdt_ahb_ap_t;

endpackage

// File: rtl/wdt_top.sv
// Watchdog timer with keyed feed sequence, AHB-Lite register slave.
// Assumes hclk domain for all inputs; timer_base_clock is a one-cycle
// enable from a divider on hclk; sys_reset_req resets the rest of the chip.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module wdt_top
    import wdt_pkg::*;
#(
    parameter int PRESC_W   = 13,
    parameter int CNT_W     = 8,
    parameter int RST_PULSE = `WDT_RST_PULSE_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        timer_base_clock,
    output logic             sys_reset_req,
    output logic             dog_timeout_flag
);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Bus slave: address phase capture, zero wait states
    wdt_ahb_ap_t     ap_next;
    wdt_ahb_ap_t     ap_reg;
    logic [31:0]     hrdata_reg;
    logic [31:0]     rdata_next;

    wire             ap_take_w = hsel & htrans[1] & hready;
    wire             acc_w     = ap_reg.valid;
    wire             wr_w      = ap_reg.valid & ap_reg.write;
    wire             wr_ctrl_w   = wr_w && (ap_reg.addr == `WDT_OFF_CTRL);
    wire             wr_reload_w = wr_w && (ap_reg.addr == `WDT_OFF_RELOAD);
    wire             wr_feed1_w  = wr_w && (ap_reg.addr == `WDT_OFF_FEED1);
    wire             wr_feed2_w  = wr_w && (ap_reg.addr == `WDT_OFF_FEED2);
    wire             key1_ok_w   = (hwdata[7:0] == `WDT_KEY_FIRST);
    wire             key2_ok_w   = (hwdata[7:0] == `WDT_KEY_SECOND);

    assign ap_next.valid = ap_take_w;
    assign ap_next.write = hwrite;
    assign ap_next.addr  = haddr[7:0];
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_reg     <= '0;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            if (hready) begin
                ap_reg <= ap_next;
            end
            if (ap_take_w && !hwrite) begin
                hrdata_reg <= rdata_next;
            end
        end
    end

    // Watchdog state
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic [CNT_W-1:0]   cnt_reg;
    logic [CNT_W-1:0]   cnt_next;
    logic [CNT_W-1:0]   reload_reg;
    logic [2:0]         tap_reg;
    logic               run_reg;
    logic               tof_reg;
    logic               tof_next;
    logic [2:0]         pend_tap_reg;
    logic               pend_run_reg;
    wdt_feed_state_t    feed_reg;
    wdt_feed_state_t    feed_next;
    logic [7:0]         rst_cnt_reg;
    logic [7:0]         rst_cnt_next;
    logic               sys_rst_reg;

    // Tap decode: low (5 + select) prescaler bits all ones marks one period
    wire [3:0]          tap_bits_w = `WDT_TAP_BASE + {1'b0, tap_reg};
    wire [PRESC_W-1:0]  tap_mask_w = ~({PRESC_W{1'b1}} << tap_bits_w);
    wire                presc_en_w = run_reg & timer_base_clock;
    wire                tick_w     = presc_en_w && ((presc_reg & tap_mask_w) == tap_mask_w);
    wire                underflow_w = tick_w && (cnt_reg == '0);

    // Feed sequencer
    wire   armed_w     = (feed_reg == WDT_FEED_ARMED);
    wire   feed_done_w = armed_w & wr_feed2_w & key2_ok_w;
    wire   violation_w = armed_w & acc_w & ~(wr_feed2_w & key2_ok_w);
    wire   autoload_w  = feed_done_w | underflow_w | violation_w;
    wire   dog_reset_w = underflow_w | violation_w;
    wire   load_or_tick_w = autoload_w | tick_w;

    always_comb begin
        feed_next = feed_reg;
        unique case (feed_reg)
            WDT_FEED_IDLE: begin
                if (wr_feed1_w && key1_ok_w) begin
                    feed_next = WDT_FEED_ARMED;
                end
            end
            WDT_FEED_ARMED: begin
                if (acc_w) begin
                    feed_next = WDT_FEED_IDLE;
                end
            end
        endcase
    end

    assign presc_next = autoload_w ? '0 :
                        presc_en_w ? PRESC_W'(presc_reg + 1'b1) : presc_reg;
    assign cnt_next   = autoload_w ? reload_reg :
                        tick_w ? CNT_W'(cnt_reg - 1'b1) : cnt_reg;
    // Set beats a coincident software clear
    assign tof_next   = dog_reset_w ? 1'b1 :
                        (wr_ctrl_w && !hwdata[`WDT_BIT_TOF]) ? 1'b0 : tof_reg;
    assign rst_cnt_next = dog_reset_w ? 8'(RST_PULSE) :
                          (rst_cnt_reg != 8'h00) ? 8'(rst_cnt_reg - 1'b1) : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_reg    <= '0;
            cnt_reg      <= CNT_W'(`WDT_RST_RELOAD);
            reload_reg   <= CNT_W'(`WDT_RST_RELOAD);
            tap_reg      <= `WDT_RST_TAP;
            run_reg      <= `WDT_RST_RUN;
            tof_reg      <= 1'b0;
            pend_tap_reg <= `WDT_RST_TAP;
            pend_run_reg <= `WDT_RST_RUN;
            feed_reg     <= WDT_FEED_IDLE;
            rst_cnt_reg  <= 8'h00;
            sys_rst_reg  <= 1'b0;
        end else begin
            presc_reg   <= presc_next;
            cnt_reg     <= cnt_next;
            tof_reg     <= tof_next;
            feed_reg    <= feed_next;
            rst_cnt_reg <= rst_cnt_next;
            sys_rst_reg <= (rst_cnt_next != 8'h00);
            if (wr_reload_w) begin
                reload_reg <= hwdata[CNT_W-1:0];
            end
            if (wr_ctrl_w) begin
                pend_tap_reg <= hwdata[`WDT_BIT_TAP_HI:`WDT_BIT_TAP_LO];
                pend_run_reg <= hwdata[`WDT_BIT_RUN];
            end
            if (feed_done_w) begin
                tap_reg <= pend_tap_reg;
                run_reg <= pend_run_reg;
            end
        end
    end

    assign sys_reset_req    = sys_rst_reg;
    assign dog_timeout_flag = tof_reg;

    // Read mux, selected in the address phase
    wire [7:0] ctrl_rd_w = {tap_reg, 2'b00, run_reg, tof_reg, 1'b0};
    wire [7:0] pend_rd_w = {pend_tap_reg, 2'b00, pend_run_reg, 2'b00};
    wire [7:0] ra_w      = haddr[7:0];

    assign rdata_next = (ra_w == `WDT_OFF_CTRL)   ? {24'h000000, ctrl_rd_w} :
                        (ra_w == `WDT_OFF_RELOAD) ? {24'h000000, 8'(reload_reg)} :
                        (ra_w == `WDT_OFF_STATUS) ? {16'h0000, pend_rd_w, 8'(cnt_reg)} :
                        32'h0000_0000;

    // Checks
    sequence s_first_key;
        wr_feed1_w && key1_ok_w && !armed_w;
    endsequence

    sequence s_second_key;
        armed_w && wr_feed2_w && key2_ok_w;
    endsequence

    property p_reset_defaults;
        $rose(hresetn) |-> run_reg && !tof_reg && (tap_reg == 3'h7) && (presc_reg == '0)
                           && (cnt_reg == '0) && (reload_reg == '0);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset defaults");

    property p_run_at_reset;
        $rose(hresetn) |-> run_reg ##1 (presc_reg == PRESC_W'($past(timer_base_clock)));
    endproperty
    a_run_at_reset: assert property (p_run_at_reset) else $error("not counting after reset");

    property p_underflow_reload;
        underflow_w |=> (cnt_reg == $past(reload_reg)) && (presc_reg == '0);
    endproperty
    a_underflow_reload: assert property (p_underflow_reload) else $error("no reload");

    property p_counter_source;
        $changed(cnt_reg) |-> $past(load_or_tick_w);
    endproperty
    a_counter_source: assert property (p_counter_source) else $error("stray counter load");

    property p_feed_autoload;
        s_first_key ##[1:8] s_second_key |=> (cnt_reg == $past(reload_reg)) && !sys_reset_req
                                        && (feed_reg == WDT_FEED_IDLE);
    endproperty
    a_feed_autoload: assert property (p_feed_autoload) else $error("feed did not reload");

    property p_intervening_access;
        armed_w && acc_w && !wr_feed2_w |=> sys_reset_req && tof_reg;
    endproperty
    a_intervening_access: assert property (p_intervening_access) else $error("no violation");

    property p_bad_second_key;
        s_first_key ##[1:8] (armed_w && wr_feed2_w && !key2_ok_w) |=> sys_reset_req;
    endproperty
    a_bad_second_key: assert property (p_bad_second_key) else $error("bad key accepted");

    property p_ctrl_pending;
        wr_ctrl_w && !feed_done_w |=> $stable(tap_reg) && $stable(run_reg);
    endproperty
    a_ctrl_pending: assert property (p_ctrl_pending) else $error("control took early");

    property p_stopped;
        !run_reg && !autoload_w |=> $stable(cnt_reg) && $stable(presc_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counting while stopped");

    property p_underflow_keeps;
        underflow_w && !feed_done_w |=> tof_reg && $stable(tap_reg) && $stable(run_reg);
    endproperty
    a_underflow_keeps: assert property (p_underflow_keeps) else $error("underflow state");

    property p_flag_clear;
        wr_ctrl_w && !hwdata[1] && !dog_reset_w |=> !tof_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_pulse_len;
        $rose(sys_reset_req) |-> sys_reset_req[*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse short");

    property p_wrong_first_key;
        wr_feed1_w && !key1_ok_w && !armed_w && !dog_reset_w |=> !armed_w && !$rose(sys_reset_req);
    endproperty
    a_wrong_first_key: assert property (p_wrong_first_key) else $error("bad first key");

    property p_tap_floor;
        tick_w |-> (presc_reg[4:0] == 5'h1F);
    endproperty
    a_tap_floor: assert property (p_tap_floor) else $error("tick off the tap");

    property p_default_tap;
        tick_w && (tap_reg == 3'h7) |-> (presc_reg[11:0] == 12'hFFF);
    endproperty
    a_default_tap: assert property (p_default_tap) else $error("default period short");

    property p_presc_clear;
        autoload_w |=> (presc_reg == '0);
    endproperty
    a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept");

    property p_reload_write;
        wr_reload_w |=> (reload_reg == $past(hwdata[CNT_W-1:0]));
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload not taken");

    property p_ctrl_apply;
        feed_done_w |=> (tap_reg == $past(pend_tap_reg)) && (run_reg == $past(pend_run_reg));
    endproperty
    a_ctrl_apply: assert property (p_ctrl_apply) else $error("control not applied");

    property p_reload_keeps;
        underflow_w && !wr_reload_w |=> $stable(reload_reg);
    endproperty
    a_reload_keeps: assert property (p_reload_keeps) else $error("reload lost");

endmodule
`default_nettype wire

// File: tb/test_watchdog_timer_with_feed_sequence.sv
// Self-checking bench for the watchdog: register access, feed keys, timeouts.
// Assumes the design header and package are compiled first; single AHB slave.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end

module test_watchdog_timer_with_feed_sequence;
    localparam int RST_PULSE = 16;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        tbc = 1'b0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sys_reset_req;
    logic        dog_timeout_flag;
    logic [2:0]  t;
    logic [2:0]  eff = 3'h7;
    logic [7:0]  w;
    int          seed = 32'hc936;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          pulses = 0;
    int          p0 = 0;
    int          n;
    int          k;

    wdt_top #(.RST_PULSE(RST_PULSE)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_base_clock(tbc),
        .sys_reset_req(sys_reset_req), .dog_timeout_flag(dog_timeout_flag)
    );

    always #4 hclk = ~hclk;

    // Random timer clock pulses; pulses counts those the design may see
    always @(posedge hclk) begin
        tbc <= 1'($random(seed));
        cyc++;
        if (hresetn === 1'b1 && tbc === 1'b1) pulses++;
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr_en;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        ahb(1'b1, a, {24'h000000, d}, r);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        `CHK(r[7:0], e)
    endtask

    task automatic feed();
        wr(`WDT_OFF_FEED1, `WDT_KEY_FIRST);
        wr(`WDT_OFF_FEED2, `WDT_KEY_SECOND);
    endtask

    // Pulses since p0 and cycles waited until the reset request shows
    task automatic wait_req(output int np, output int nk);
        nk = 0;
        while (sys_reset_req !== 1'b1 && nk < 20000) begin
            @(posedge hclk);
            #1;
            nk++;
        end
        np = pulses - p0;
    endtask

    function automatic logic [7:0] cb(input logic [2:0] tp, input logic run, input logic tof);
        return {tp, 2'b00, run, tof, 1'b0};
    endfunction

    function automatic int tmo(input logic [2:0] tp, input logic [7:0] rv);
        return (1 << (`WDT_TAP_BASE + tp)) * (rv + 1);
    endfunction

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        chk_rd(`WDT_OFF_CTRL, 8'hE4);
        chk_rd(`WDT_OFF_RELOAD, 8'h00);
        chk_rd(`WDT_OFF_FEED1, 8'h00);
        chk_rd(8'h20, 8'h00);
        `CHK(dog_timeout_flag, 1'b0)
        wait_req(n, k);
        `CHK(n == 4096 || n == 4097, 1'b1)
        k = 0;
        while (sys_reset_req === 1'b1 && k < 100) begin
            @(posedge hclk);
            #1;
            k++;
        end
        `CHK(k, RST_PULSE)
        `CHK(dog_timeout_flag, 1'b1)
        chk_rd(`WDT_OFF_CTRL, 8'hE6);
        wr(`WDT_OFF_CTRL, 8'hE4);
        #1;
        `CHK(dog_timeout_flag, 1'b0)
        // Corner reloads first, then random taps and reloads
        for (int i = 0; i < 4; i++) begin
            #1;
            t = (i < 2) ? 3'h0 : 3'($random(seed)) % 3'h4;
            w = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed)) & 8'h07;
            wr(`WDT_OFF_RELOAD, w);
            wr(`WDT_OFF_CTRL, cb(t, 1'b1, 1'b0));
            chk_rd(`WDT_OFF_CTRL, cb(eff, 1'b1, 1'b0));
            feed();
            #1;
            p0 = pulses;
            chk_rd(`WDT_OFF_STATUS, w);
            chk_rd(`WDT_OFF_CTRL, cb(t, 1'b1, 1'b0));
            wait_req(n, k);
            `CHK(n == tmo(t, w) || n == tmo(t, w) + 1, 1'b1)
            chk_rd(`WDT_OFF_CTRL, cb(t, 1'b1, 1'b1));
            repeat (20) @(posedge hclk);
            wr(`WDT_OFF_CTRL, cb(t, 1'b1, 1'b0));
            eff = t;
        end
        wr(`WDT_OFF_CTRL, 8'h00);
        wr(`WDT_OFF_RELOAD, 8'h05);
        feed();
        chk_rd(`WDT_OFF_CTRL, 8'h00);
        repeat (300) @(posedge hclk);
        chk_rd(`WDT_OFF_STATUS, 8'h05);
        wr(`WDT_OFF_FEED1, 8'h11);
        wr(`WDT_OFF_FEED2, `WDT_KEY_SECOND);
        repeat (3) @(posedge hclk);
        #1;
        `CHK(sys_reset_req, 1'b0)
        // Read between the keys, then a wrong second key
        wr(`WDT_OFF_FEED1, `WDT_KEY_FIRST);
        chk_rd(8'h20, 8'h00);
        wait_req(n, k);
        `CHK(k, 1)
        `CHK(dog_timeout_flag, 1'b1)
        repeat (20) @(posedge hclk);
        wr(`WDT_OFF_CTRL, 8'h00);
        wr(`WDT_OFF_FEED1, `WDT_KEY_FIRST);
        wr(`WDT_OFF_FEED2, 8'h5B);
        wait_req(n, k);
        `CHK(k, 1)
        chk_rd(`WDT_OFF_CTRL, 8'h02);
        // Reset in mid-run drops the pending pulse and flag, restores defaults
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        `CHK(sys_reset_req, 1'b0)
        `CHK(dog_timeout_flag, 1'b0)
        @(posedge hclk);
        hresetn <= 1'b1;
        chk_rd(`WDT_OFF_CTRL, 8'hE4);
        chk_rd(`WDT_OFF_STATUS, 8'h00);
        stop_test();
    end
endmodule

`default_nettype wire
